// file: scp_top.sv
// Functional notes
// - Regulating bridges alternate commanded drive with low-side short brake.
// - Each leg holds both switches off 300 ns before switching sides.
// - Dead time applies on every change, reversal and brake included.
// - Sense reaching reference starts discharge for four oscillator periods.
// - After four charge periods, sense above reference re-enters discharge.
// - Below reference after discharge, charge continues until reference reached.
// - Unless the bridge is shut off, a discharge interval runs to its fourth oscillator tick, three to four periods.
// - Over-temperature indication turns every output transistor off.
// - Outputs return automatically when over-temperature indication clears.
// - Any of eight overcurrent flags turns all eight transistors off.
// - Overcurrent shutdown holds outputs off 50 us, then restarts.
// - Returning overcurrent repeats the shutdown and retry cycle indefinitely.
// - Overcurrent counts only after 10 us of continuous flag.
`timescale 1ns/1ns
`default_nettype none
module scp_top
  import scp_pkg::*;
(
  input  wire logic           core_clk,
  input  wire logic           rst_b,
  input  wire logic           sleep_select,
  input  wire logic           dir_a,
  input  wire logic           dir_b,
  input  wire logic           level_sel_hi_a,
  input  wire logic           level_sel_lo_a,
  input  wire logic           level_sel_hi_b,
  input  wire logic           level_sel_lo_b,
  input  wire logic [1:0]     sense_voltage_over,
  input  wire logic [7:0]     overcurrent_cutoff,
  input  wire logic           thermal_cutoff,
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [7:0]     paddr,
  input  wire logic [31:0]    pwdata,
  output logic [31:0]         prdata,
  output logic                pready,
  output logic                pslverr,
  output scp_pkg::scp_gate_s  gate_a,
  output scp_pkg::scp_gate_s  gate_b,
  output logic                irq
);
  import scp_pkg::*;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n = rst_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  localparam int unsigned SYN_W = 18;

  logic [SYN_W-1:0] pin_raw;
  logic [SYN_W-1:0] pin_s1;
  logic [SYN_W-1:0] pin_s2;

  assign pin_raw = {thermal_cutoff, overcurrent_cutoff, sense_voltage_over,
                    level_sel_lo_b, level_sel_hi_b, level_sel_lo_a,
                    level_sel_hi_a, dir_b, dir_a, sleep_select};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end

  logic       awake;
  logic [1:0] dir_s;
  logic [3:0] lvl_s;
  logic [1:0] over_s;
  logic [7:0] oc_s;
  logic       therm_s;

  assign awake   = pin_s2[0];
  assign dir_s   = pin_s2[2:1];
  assign lvl_s   = pin_s2[6:3];
  assign over_s  = pin_s2[8:7];
  assign oc_s    = pin_s2[16:9];
  assign therm_s = pin_s2[17];

  ////////////////////////////////////////////////////////////////////////////
  // Chopper time base

  logic [6:0] osc_cnt;
  logic       osc_tick;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt  <= 7'h00;
      osc_tick <= 1'b0;
    end else begin
      osc_tick <= (osc_cnt == 7'(OSC_DIV - 1));
      osc_cnt  <= (osc_cnt == 7'(OSC_DIV - 1)) ? 7'h00 : osc_cnt + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overcurrent filter and retry

  scp_oc_e    oc_state;
  logic [6:0] oc_filt;
  logic [8:0] oc_hold;
  logic       oc_trip;

  // One shared filter: it restarts when every flag is low, in standby or during the shutdown hold
  assign oc_trip = (oc_state == OC_RUN) && (|oc_s) &&
                   (oc_filt == 7'(OC_FILT_CYC - 1));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      oc_filt <= 7'h00;
    end else if (!awake || !(|oc_s) || oc_state != OC_RUN) begin
      oc_filt <= 7'h00;
    end else if (!oc_trip) begin
      oc_filt <= oc_filt + 7'h01;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      oc_state <= OC_RUN;
      oc_hold  <= 9'h000;
    end else if (!awake) begin
      oc_state <= OC_RUN;
      oc_hold  <= 9'h000;
    end else begin
      unique case (oc_state)
        OC_RUN: begin
          if (oc_trip) begin
            oc_state <= OC_HOLD;
            oc_hold  <= 9'h000;
          end
        end
        OC_HOLD: begin
          if (oc_hold == 9'(OC_HOLD_CYC - 1)) begin
            oc_state <= OC_RUN;
          end else begin
            oc_hold <= oc_hold + 9'h001;
          end
        end
        default: begin
          oc_state <= OC_RUN;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Thermal shutdown

  logic therm_off;

  // Hysteresis lives in the analog sensor; logic follows the flag
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      therm_off <= 1'b0;
    end else begin
      therm_off <= therm_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic             drv_en;
  logic [INT_W-1:0] int_stat;
  logic [INT_W-1:0] int_en;
  logic [INT_W-1:0] int_evt;
  logic             setup;
  logic             wr_acc;
  logic             mapped;
  logic [31:0]      next_rdata;
  logic [31:0]      status;
  scp_chop_e        phase_a;
  scp_chop_e        phase_b;

  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pready && pwrite;
  assign mapped = hit(paddr, CTRL_OFF) || hit(paddr, STATUS_OFF) ||
                  hit(paddr, INT_STAT_OFF) || hit(paddr, INT_CLR_OFF) ||
                  hit(paddr, INT_EN_OFF);

  always_comb begin
    status               = 32'h0;
    status[ST_THERM]     = therm_off;
    status[ST_OC_OFF]    = (oc_state == OC_HOLD);
    status[ST_STANDBY]   = !awake;
    status[ST_DISCH_A]   = (phase_a != CH_CHARGE);
    status[ST_DISCH_B]   = (phase_b != CH_CHARGE);
    status[ST_OC_FILT]   = (oc_filt != 7'h00);
  end

  always_comb begin
    next_rdata = 32'h0;
    if (hit(paddr, CTRL_OFF)) begin
      next_rdata[CTRL_DRV_EN] = drv_en;
    end else if (hit(paddr, STATUS_OFF)) begin
      next_rdata = status;
    end else if (hit(paddr, INT_STAT_OFF)) begin
      next_rdata[INT_W-1:0] = int_stat;
    end else if (hit(paddr, INT_EN_OFF)) begin
      next_rdata[INT_W-1:0] = int_en;
    end
  end

  // Answer one cycle after setup: pready and data both registered
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite) begin
        prdata <= next_rdata;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      drv_en <= CTRL_RST;
      int_en <= INT_EN_RST;
    end else if (wr_acc && hit(paddr, CTRL_OFF)) begin
      drv_en <= pwdata[CTRL_DRV_EN];
    end else if (wr_acc && hit(paddr, INT_EN_OFF)) begin
      int_en <= pwdata[INT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts

  logic therm_prev;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      therm_prev <= 1'b0;
    end else begin
      therm_prev <= therm_off;
    end
  end

  assign int_evt[INT_OC]        = oc_trip;
  assign int_evt[INT_THERM]     = therm_off && !therm_prev;
  assign int_evt[INT_THERM_CLR] = !therm_off && therm_prev;

  // New event beats a simultaneous clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_stat <= '0;
    end else if (wr_acc && hit(paddr, INT_CLR_OFF)) begin
      int_stat <= (int_stat & ~pwdata[INT_W-1:0]) | int_evt;
    end else begin
      int_stat <= int_stat | int_evt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_stat & int_en);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bridges

  logic      kill;
  scp_chop_e phase [2];
  logic      on    [2];
  scp_leg_e  req   [4];
  logic      g_hi  [4];
  logic      g_lo  [4];

  assign kill = !awake || !drv_en || therm_off || (oc_state != OC_RUN);
  assign on[0] = !kill && !(lvl_s[0] && lvl_s[1]);
  assign on[1] = !kill && !(lvl_s[2] && lvl_s[3]);
  assign phase_a = phase[0];
  assign phase_b = phase[1];

  genvar b;
  generate
    for (b = 0; b < 2; b++) begin : g_br
      scp_chopper u_chop (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .run      (on[b]),
        .osc_tick (osc_tick),
        .over_ref (over_s[b]),
        .phase    (phase[b])
      );

      always_comb begin
        if (!on[b]) begin
          req[2*b]   = LEG_OFF;
          req[2*b+1] = LEG_OFF;
        end else if (phase[b] == CH_DISCH) begin
          req[2*b]   = LEG_LOW;
          req[2*b+1] = LEG_LOW;
        end else begin
          req[2*b]   = dir_s[b] ? LEG_HIGH : LEG_LOW;
          req[2*b+1] = dir_s[b] ? LEG_LOW : LEG_HIGH;
        end
      end

      for (genvar l = 0; l < 2; l++) begin : g_leg
        scp_leg u_leg (
          .core_clk (core_clk),
          .rst_n    (rst_n),
          .req      (req[2*b+l]),
          .gate_hi  (g_hi[2*b+l]),
          .gate_lo  (g_lo[2*b+l])
        );
      end
    end
  endgenerate

  assign gate_a = '{hi1: g_hi[0], lo1: g_lo[0], hi2: g_hi[1], lo2: g_lo[1]};
  assign gate_b = '{hi1: g_hi[2], lo1: g_lo[2], hi2: g_hi[3], lo2: g_lo[3]};

endmodule
`default_nettype wire

// file: scp_pkg.sv
package scp_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned DEAD_NS       = 300;
  localparam int unsigned DEAD_CYC      = (DEAD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned OC_FILT_US    = 10;
  localparam int unsigned OC_FILT_CYC   = OC_FILT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned OC_HOLD_US    = 50;
  localparam int unsigned OC_HOLD_CYC   = OC_HOLD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned OSC_DIV       = 91;
  localparam int unsigned CHOP_TICKS    = 4;
  localparam int unsigned NUM_FETS      = 8;

  // Register offsets
  localparam logic [7:0] CTRL_OFF       = 8'h00;
  localparam logic [7:0] STATUS_OFF     = 8'h04;
  localparam logic [7:0] INT_STAT_OFF   = 8'h08;
  localparam logic [7:0] INT_CLR_OFF    = 8'h0c;
  localparam logic [7:0] INT_EN_OFF     = 8'h10;

  // Field positions
  localparam int unsigned CTRL_DRV_EN   = 0;
  localparam int unsigned ST_THERM      = 0;
  localparam int unsigned ST_OC_OFF     = 1;
  localparam int unsigned ST_STANDBY    = 2;
  localparam int unsigned ST_DISCH_A    = 3;
  localparam int unsigned ST_DISCH_B    = 4;
  localparam int unsigned ST_OC_FILT    = 5;
  localparam int unsigned INT_W         = 3;
  localparam int unsigned INT_OC        = 0;
  localparam int unsigned INT_THERM     = 1;
  localparam int unsigned INT_THERM_CLR = 2;

  // Reset values
  localparam logic        CTRL_RST      = 1'b1;
  localparam logic [2:0]  INT_EN_RST    = 3'h0;

  typedef enum logic [2:0] {
    LEG_OFF  = 3'b001,
    LEG_HIGH = 3'b010,
    LEG_LOW  = 3'b100
  } scp_leg_e;

  typedef enum logic [2:0] {
    CH_CHARGE = 3'b001,
    CH_BLANK  = 3'b010,
    CH_DISCH  = 3'b100
  } scp_chop_e;

  typedef enum logic [1:0] {
    OC_RUN  = 2'b01,
    OC_HOLD = 2'b10
  } scp_oc_e;

  typedef struct packed {
    logic hi1;
    logic lo1;
    logic hi2;
    logic lo2;
  } scp_gate_s;

endpackage

// file: scp_leg.sv
`timescale 1ns/1ns
`default_nettype none
module scp_leg
  import scp_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire scp_pkg::scp_leg_e req,
  output logic                   gate_hi,
  output logic                   gate_lo
);
  import scp_pkg::*;

  scp_leg_e   cur;
  scp_leg_e   next_cur;
  logic [1:0] dead;

  always_comb begin
    next_cur = cur;
    if (req == LEG_OFF || (cur != LEG_OFF && req != cur)) begin
      next_cur = LEG_OFF;
    end else if (cur == LEG_OFF && dead == 2'h0) begin
      next_cur = req;
    end
  end

  // Dead counter restarts on every turn-off so both switches rest
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur  <= LEG_OFF;
      dead <= 2'h0;
    end else begin
      cur <= next_cur;
      if (cur != LEG_OFF && next_cur == LEG_OFF) begin
        dead <= 2'(DEAD_CYC - 1);
      end else if (dead != 2'h0) begin
        dead <= dead - 2'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_hi <= 1'b0;
      gate_lo <= 1'b0;
    end else begin
      gate_hi <= (next_cur == LEG_HIGH);
      gate_lo <= (next_cur == LEG_LOW);
    end
  end
endmodule
`default_nettype wire

// file: scp_chopper.sv
`timescale 1ns/1ns
`default_nettype none
module scp_chopper
  import scp_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic          run,
  input  wire logic          osc_tick,
  input  wire logic          over_ref,
  output scp_pkg::scp_chop_e phase
);
  import scp_pkg::*;

  logic [1:0] ticks;
  logic       last_tick;

  assign last_tick = osc_tick && (ticks == 2'(CHOP_TICKS - 1));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= CH_CHARGE;
      ticks <= 2'h0;
    end else if (!run) begin
      phase <= CH_CHARGE;
      ticks <= 2'h0;
    end else begin
      if (osc_tick) begin
        ticks <= last_tick ? 2'h0 : ticks + 2'h1;
      end
      unique case (phase)
        CH_CHARGE: begin
          if (over_ref) begin
            phase <= CH_DISCH;
            ticks <= 2'h0;
          end
        end
        CH_DISCH: begin
          // Comparator ignored here, interval runs out unless run drops
          if (last_tick) begin
            phase <= CH_BLANK;
          end
        end
        CH_BLANK: begin
          if (last_tick) begin
            phase <= over_ref ? CH_DISCH : CH_CHARGE;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: scp_checker.sv
`timescale 1ns/1ns
`default_nettype none
module scp_checker
  import scp_pkg::*;
(
  input wire logic               core_clk,
  input wire logic               rst_b,
  input wire logic               sleep_select,
  input wire logic [7:0]         overcurrent_cutoff,
  input wire logic               thermal_cutoff,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pready,
  input wire scp_pkg::scp_gate_s gate_a,
  input wire scp_pkg::scp_gate_s gate_b
);
  import scp_pkg::*;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  logic       brk;
  logic       armed;
  logic [8:0] brk_len;
  logic [7:0] oc_run;

  assign brk = (gate_a == 4'h5);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) brk_len <= 9'h0;
    else brk_len <= brk ? brk_len + 9'h1 : 9'h0;
  end

  // Brake resumed after a kill is cut short, so only time brakes entered from drive
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) armed <= 1'h0;
    else if (gate_a == 4'h0) armed <= 1'h0;
    else if (gate_a.hi1 || gate_a.hi2) armed <= 1'h1;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) oc_run <= 8'h0;
    else if (overcurrent_cutoff == 8'h0) oc_run <= 8'h0;
    else if (oc_run != 8'hff) oc_run <= oc_run + 8'h1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  AST_DEAD_A_HI: assert property ($fell(gate_a.hi1) |-> !gate_a.lo1 [*3])
    else $error("leg a1 low side on within dead time");
  AST_DEAD_A_LO: assert property ($fell(gate_a.lo1) |-> !gate_a.hi1 [*3])
    else $error("leg a1 high side on within dead time");
  AST_DEAD_B: assert property ($fell(gate_b.hi2) |-> !gate_b.lo2 [*3])
    else $error("leg b2 low side on within dead time");
  AST_THERM: assert property (thermal_cutoff [*5] |-> {gate_a, gate_b} == 8'h00)
    else $error("gates on during thermal cutoff");
  AST_SLEEP: assert property (!sleep_select [*5] |-> {gate_a, gate_b} == 8'h00)
    else $error("gates on during standby");
  AST_OC_TRIP: assert property (oc_run == 8'h69 |-> ##[0:4] {gate_a, gate_b} == 8'h00)
    else $error("overcurrent did not turn gates off");
  AST_BRAKE_LEN: assert property ($fell(brk) && armed && sleep_select
    && !thermal_cutoff && overcurrent_cutoff == 8'h00
    |-> brk_len inside {[9'h104:9'h16c]})
    else $error("brake interval length wrong");
  AST_PREADY: assert property (psel && !penable |=> pready)
    else $error("no ready in access phase");
  AST_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
endmodule
`default_nettype wire

// file: scp_coil.sv
`timescale 1ns/1ns
`default_nettype none
module scp_coil
  import scp_pkg::*;
#(
  parameter int TRIP = 400
)
(
  input  wire logic               core_clk,
  input  wire logic               slow,
  input  wire scp_pkg::scp_gate_s g,
  output logic                    over
);
  import scp_pkg::*;

  int cur = 0;

  // Coil current ramps while driven, decays in brake or off; stops decaying at zero or one
  // Slow ramp stays below the trip point after one blank, so charge runs on
  always @(posedge core_clk) begin
    if ((g.hi1 && g.lo2) || (g.hi2 && g.lo1)) cur <= cur + (slow ? 1 : 2);
    else if (cur > 1) cur <= cur - 2;
  end

  assign over = (cur > TRIP);
endmodule
`default_nettype wire

// file: scp_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module scp_top_bench;
  import scp_pkg::*;
  logic        core_clk = 1'h0;
  logic        rst_b = 1'h0;
  logic        sleep_select = 1'h0;
  logic        dir_a = 1'h1;
  logic        level_sel_hi_b = 1'h0;
  logic        level_sel_lo_b = 1'h0;
  logic [7:0]  overcurrent_cutoff = 8'h00;
  logic        thermal_cutoff = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rdat;
  logic        pready;
  logic        pslverr;
  logic        rerr;
  logic        irq;
  logic        slow = 1'h0;
  wire [1:0]   over;
  scp_gate_s   gate_a;
  scp_gate_s   gate_b;
  int          n_mismatch = 0;
  int          checks = 0;

  scp_top u_dut (.core_clk, .rst_b, .sleep_select, .dir_a, .dir_b(1'h1),
    .level_sel_hi_a(1'h0), .level_sel_lo_a(1'h0), .level_sel_hi_b, .level_sel_lo_b,
    .sense_voltage_over(over), .overcurrent_cutoff, .thermal_cutoff, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .gate_a, .gate_b, .irq);
  scp_coil u_coil_a (.core_clk, .slow, .g(gate_a), .over(over[0]));
  scp_coil u_coil_b (.core_clk, .slow, .g(gate_b), .over(over[1]));

  always #50 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic w(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] gates();
    return {24'h0, gate_a, gate_b};
  endfunction

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    do @(posedge core_clk); while (pready !== 1'h1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic give_verdict();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    apb(1'h0, CTRL_OFF, 32'h0);
    chk(rdat, 32'h1);
    apb(1'h0, INT_EN_OFF, 32'h0);
    chk(rdat, 32'h0);
    apb(1'h1, INT_EN_OFF, 32'h7);
    apb(1'h0, INT_EN_OFF, 32'h0);
    chk(rdat, 32'h7);
    apb(1'h0, 8'h40, 32'h0);
    chk({rdat[30:0], rerr}, 32'h1);
    apb(1'h1, CTRL_OFF, 32'h0);
    w(4);
    chk(gates(), 32'h0);
    apb(1'h1, CTRL_OFF, 32'h1);
    w(8);
    chk(gates(), 32'h99);
  endtask

  // Drive must match direction, longest brake must last 270 to 364 cycles
  // Fast coil re-trips after each blank; slow coil keeps charging past it
  task automatic t_chop(input logic d, input logic [3:0] drive, input logic sl);
    int brk;
    int drv;
    int bad;
    int run;
    int mx;
    int dr;
    int mxd;
    brk = 0;
    drv = 0;
    bad = 0;
    run = 0;
    mx = 0;
    dr = 0;
    mxd = 0;
    dir_a <= d;
    slow <= sl;
    w(5);
    repeat (2500) begin
      @(posedge core_clk);
      if (gate_a === 4'h5) run++;
      else run = 0;
      if (gate_a === drive) dr++;
      else dr = 0;
      if (run > 0) brk++;
      if (run > mx) mx = run;
      if (dr > mxd) mxd = dr;
      if (gate_a === drive) drv++;
      if (gate_a === ~drive) bad++;
    end
    chk({31'h0, brk > 0 && drv > 0 && bad == 0}, 32'h1);
    chk({31'h0, mx >= 270 && mx <= 364}, 32'h1);
    chk({31'h0, mxd > 364}, {31'h0, sl});
  endtask

  task automatic t_therm();
    thermal_cutoff <= 1'h1;
    w(8);
    chk(gates(), 32'h0);
    apb(1'h0, INT_STAT_OFF, 32'h0);
    chk(rdat, 32'h2);
    chk({31'h0, irq}, 32'h1);
    apb(1'h1, INT_CLR_OFF, 32'h2);
    w(3);
    chk({31'h0, irq}, 32'h0);
    thermal_cutoff <= 1'h0;
    w(10);
    chk({31'h0, gates() != 32'h0}, 32'h1);
    apb(1'h0, INT_STAT_OFF, 32'h0);
    chk(rdat, 32'h4);
    apb(1'h1, INT_EN_OFF, 32'h3);
    w(3);
    chk({31'h0, irq}, 32'h0);
    apb(1'h1, INT_CLR_OFF, 32'h4);
    apb(1'h1, INT_EN_OFF, 32'h7);
  endtask

  task automatic t_oc();
    overcurrent_cutoff <= 8'h10;
    w(90);
    overcurrent_cutoff <= 8'h00;
    w(4);
    apb(1'h0, STATUS_OFF, 32'h0);
    chk(rdat & 32'h2, 32'h0);
    for (int k = 0; k < 8; k++) begin
      overcurrent_cutoff <= 8'h01 << k;
      w(110);
      chk(gates(), 32'h0);
      apb(1'h0, STATUS_OFF, 32'h0);
      chk(rdat & 32'h2, 32'h2);
      w(390);
      overcurrent_cutoff <= 8'h00;
      chk(gates(), 32'h0);
      w(160);
      chk({31'h0, gates() != 32'h0}, 32'h1);
    end
    apb(1'h0, INT_STAT_OFF, 32'h0);
    chk(rdat, 32'h1);
  endtask

  // Long standby lets the coils discharge so restart begins below the trip point
  task automatic t_sleep();
    sleep_select <= 1'h0;
    w(500);
    chk(gates(), 32'h0);
    apb(1'h0, STATUS_OFF, 32'h0);
    chk(rdat, 32'h4);
    level_sel_hi_b <= 1'h1;
    level_sel_lo_b <= 1'h1;
    sleep_select <= 1'h1;
    w(10);
    chk(gates(), 32'h60);
    level_sel_hi_b <= 1'h0;
    level_sel_lo_b <= 1'h0;
    w(10);
    chk(gates(), 32'h69);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    w(5);
    rst_b <= 1'h1;
    w(3);
    sleep_select <= 1'h1;
    w(6);
    t_regs();
    t_chop(1'h1, 4'h9, 1'h0);
    t_chop(1'h0, 4'h6, 1'h1);
    t_therm();
    t_oc();
    t_sleep();
    give_verdict();
  end

  // Run needs about 11000 cycles; cut off well beyond
  initial begin
    #3000000;
    n_mismatch++;
    give_verdict();
  end
endmodule

bind scp_top scp_checker u_chk (.core_clk, .rst_b, .sleep_select, .overcurrent_cutoff,
  .thermal_cutoff, .psel, .penable, .pready, .gate_a, .gate_b);
`default_nettype wire
